/* hw/pmes_top.sv */
// Performance-monitor event selection with two 64-bit control registers behind APB.
// Assumes event, qualifier and memory-bus signals come from logic on pclk.
//
// Function
// - Both control registers clear to zero on system reset.
// - Bits 61:52 of the select register hold the mask for counters 2 and 3.
// - Bits 39:36 choose wrap (1) or saturate at all ones (0) per counter.
// - Bits 33:32 pick which memory signal set drives memory monitor bits 15:0.
// - Memory monitor bits 20:16 carry fixed signals, unaffected by any field.
// - Four 8-bit choices pick each monitor output and counted event.
// - Bit 0 of the second register forces mon_out to zero; memory monitor bits are not gated.
// - Some monitor sources are tied to one particular processor.
// - Counters 0,1 use low-pair mask, 2,3 high-pair mask, each own match.
// - Any write to either control register clears all counters.
`default_nettype none
`include "pmes_regs.svh"

module pmes_top #(
  parameter int CNT_W = 32
) (
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [7:0]                  paddr,
  input  wire logic [31:0]                 pwdata,
  output logic [31:0]                      prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire logic [`PMES_GEN_SRC_W-1:0]  event_src,
  input  wire logic [15:0]                 cpu0_fixed_src,
  input  wire logic [9:0]                  qual_tag,
  input  wire logic [15:0]                 mem_signal_set_0,
  input  wire logic [15:0]                 mem_signal_set_1,
  input  wire logic [15:0]                 mem_signal_set_2,
  input  wire logic [15:0]                 mem_signal_set_3,
  input  wire logic [4:0]                  mem_fixed_src,
  output logic [3:0]                       mon_out,
  output logic [20:0]                      mem_mon
);

  // ----------------------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------------------
  logic [63:0]      selmsk_q, selmsk_d;
  logic [63:0]      matgat_q, matgat_d;
  logic [31:0]      prdata_d;
  logic             pready_d, pslverr_d;
  logic [3:0]       mon_d;
  logic [20:0]      mem_d;
  logic             wr_en, ctl_wr, hit;
  logic [3:0]       evt, carry;
  logic [CNT_W-1:0] cnt [4];
  logic [31:0]      cnt_word [4];

  // A request completes in the access cycle that follows its setup cycle.
  assign wr_en  = psel && penable && pready && pwrite;
  // Only the four aligned control words clear the counters; a stray unmapped write must not.
  assign ctl_wr = wr_en && (paddr[7:4] == 4'h0) && (paddr[1:0] == 2'h0);

  // ----------------------------------------------------------------------------
  // Register write and APB answer
  // ----------------------------------------------------------------------------
  // Answer data is prepared in the setup cycle so that prdata leaves a flip-flop.
  always_comb begin
    selmsk_d  = selmsk_q;
    matgat_d  = matgat_q;
    pready_d  = psel && !penable;
    prdata_d  = '0;
    hit       = 1'b1;
    unique case (paddr)
      `PMES_OFF_SELMSK_LO: prdata_d = selmsk_q[31:0];
      `PMES_OFF_SELMSK_HI: prdata_d = selmsk_q[63:32];
      `PMES_OFF_MATGAT_LO: prdata_d = matgat_q[31:0];
      `PMES_OFF_MATGAT_HI: prdata_d = matgat_q[63:32];
      `PMES_OFF_COUNT0:    prdata_d = cnt_word[0];
      `PMES_OFF_COUNT1:    prdata_d = cnt_word[1];
      `PMES_OFF_COUNT2:    prdata_d = cnt_word[2];
      `PMES_OFF_COUNT3:    prdata_d = cnt_word[3];
      default:             hit = 1'b0;
    endcase
    pslverr_d = pready_d && !hit;
    if (!pready_d) begin
      prdata_d = prdata;
    end
    // Reserved positions are dropped on write so they always read as zero.
    if (wr_en) begin
      unique case (paddr)
        `PMES_OFF_SELMSK_LO: selmsk_d[31:0]  = pwdata & 32'(`PMES_SELMSK_WMASK);
        `PMES_OFF_SELMSK_HI: selmsk_d[63:32] = pwdata & 32'(`PMES_SELMSK_WMASK >> 32);
        `PMES_OFF_MATGAT_LO: matgat_d[31:0]  = pwdata & 32'(`PMES_MATGAT_WMASK);
        `PMES_OFF_MATGAT_HI: matgat_d[63:32] = pwdata & 32'(`PMES_MATGAT_WMASK >> 32);
        default: ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      selmsk_q <= `PMES_RST_CTL;
      matgat_q <= `PMES_RST_CTL;
      prdata   <= '0;
      pready   <= 1'b0;
      pslverr  <= 1'b0;
    end else begin
      selmsk_q <= selmsk_d;
      matgat_q <= matgat_d;
      prdata   <= prdata_d;
      pready   <= pready_d;
      pslverr  <= pslverr_d;
    end
  end

  // ----------------------------------------------------------------------------
  // Per-counter selection, qualification and counting
  // ----------------------------------------------------------------------------
  // Match entries sit at 16 + 12*n; reserved gaps of two bits keep that stride.
  for (genvar n = 0; n < 4; n++) begin : g_chan
    pmes_pkg::pmes_choice_t choice;
    pmes_pkg::pmes_qual_t   mask, match;
    logic [255:0]           srcs;
    logic                   prev_carry;
    assign choice     = selmsk_q[n*`PMES_CHOICE_W +: `PMES_CHOICE_W];
    assign mask       = (n >= 2) ? selmsk_q[`PMES_HI_MASK_LSB +: `PMES_QUAL_W]
                                 : selmsk_q[`PMES_LO_MASK_LSB +: `PMES_QUAL_W];
    assign match      = matgat_q[16 + 12*n +: `PMES_QUAL_W];
    assign prev_carry = (n == 0) ? 1'b0 : carry[(n+3)%4];
    // Top sixteen codes are processor 0's own signals, not steerable to others.
    assign srcs       = {cpu0_fixed_src, prev_carry, event_src};
    // A set mask bit makes that tag bit take part in the comparison.
    assign evt[n]     = srcs[choice] && (((qual_tag ^ match) & mask) == '0);
    assign cnt_word[n] = 32'(cnt[n]);

    pmes_counter #(.CNT_W(CNT_W)) u_cnt (
      .pclk    (pclk),
      .presetn (presetn),
      .clr     (ctl_wr),
      .inc     (evt[n]),
      .wrap_en (selmsk_q[`PMES_WRAP_LSB + n]),
      .value_q (cnt[n]),
      .carry_q (carry[n])
    );
  end

  // ----------------------------------------------------------------------------
  // Monitor pins
  // ----------------------------------------------------------------------------
  // Pins are registered, so they lag the selected signal by one cycle.
  always_comb begin
    mon_d = matgat_q[`PMES_PINS_OFF_BIT] ? 4'h0 : evt;
    unique case (selmsk_q[`PMES_MEMSEL_LSB +: 2])
      2'h0: mem_d[15:0] = mem_signal_set_0;
      2'h1: mem_d[15:0] = mem_signal_set_1;
      2'h2: mem_d[15:0] = mem_signal_set_2;
      2'h3: mem_d[15:0] = mem_signal_set_3;
    endcase
    mem_d[20:16] = mem_fixed_src;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mon_out <= '0;
      mem_mon <= '0;
    end else begin
      mon_out <= mon_d;
      mem_mon <= mem_d;
    end
  end

  // ----------------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------------
  logic [15:0] mem_pick;
  assign mem_pick = (selmsk_q[33:32] == 2'h0) ? mem_signal_set_0 :
                    (selmsk_q[33:32] == 2'h1) ? mem_signal_set_1 :
                    (selmsk_q[33:32] == 2'h2) ? mem_signal_set_2 : mem_signal_set_3;

  AST_RESET_CLEAR: assert property (@(posedge pclk) $rose(presetn) |-> (selmsk_q == '0 && matgat_q == '0))
    else $error("Control registers not zero after reset.");
  AST_PINS_OFF: assert property (@(posedge pclk) disable iff (!presetn) matgat_q[0] |=> mon_out == 4'h0)
    else $error("Monitor pins not held at zero.");
  AST_PIN_FOLLOW: assert property (@(posedge pclk) disable iff (!presetn) !matgat_q[0] |=> mon_out == $past(evt))
    else $error("Monitor pins do not follow the selected events.");
  AST_MEM_LOW: assert property (@(posedge pclk) disable iff (!presetn) 1'b1 |=> mem_mon[15:0] == $past(mem_pick))
    else $error("Memory monitor low bits from wrong set.");
  AST_MEM_FIXED: assert property (@(posedge pclk) disable iff (!presetn) 1'b1 |=> mem_mon[20:16] == $past(mem_fixed_src))
    else $error("Memory monitor fixed bits changed.");
  AST_WRITE_CLEARS: assert property (@(posedge pclk) disable iff (!presetn)
      ctl_wr |=> (cnt[0] == '0 && cnt[1] == '0 && cnt[2] == '0 && cnt[3] == '0))
    else $error("Counters not cleared by control write.");
  AST_SATURATE: assert property (@(posedge pclk) disable iff (!presetn)
      (&cnt[0]) && !selmsk_q[36] && !ctl_wr |=> &cnt[0])
    else $error("Counter 0 left all ones while saturating.");
  // The wrap must also raise the carry for exactly the cycle after it, or chaining loses counts.
  AST_WRAP: assert property (@(posedge pclk) disable iff (!presetn)
      (&cnt[0]) && selmsk_q[36] && evt[0] && !ctl_wr |=> (cnt[0] == '0 && carry[0]))
    else $error("Counter 0 did not wrap with a carry.");
  AST_CHAIN_INC: assert property (@(posedge pclk) disable iff (!presetn)
      carry[0] && selmsk_q[15:8] == `PMES_CARRY_CODE && selmsk_q[49:40] == '0 && !ctl_wr && !(&cnt[1])
      |=> cnt[1] == $past(cnt[1]) + CNT_W'(1))
    else $error("Counter 1 missed the carry of counter 0.");
  AST_RSV_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
      psel && penable && pready && !pwrite && paddr == `PMES_OFF_MATGAT_LO |-> prdata[15:1] == '0)
    else $error("Reserved bits read non-zero.");
  AST_QUAL_MASK: assert property (@(posedge pclk) disable iff (!presetn)
      selmsk_q[49:40] == '0 |-> evt[0] == g_chan[0].srcs[selmsk_q[7:0]])
    else $error("Clear low-pair mask must not block counter 0.");

  COV_WRITE: cover property (@(posedge pclk) disable iff (!presetn) ctl_wr);
  COV_WRAP_CARRY: cover property (@(posedge pclk) disable iff (!presetn) carry[0]);
  COV_ERR: cover property (@(posedge pclk) disable iff (!presetn) pslverr && psel && penable);
  COV_SATURATE: cover property (@(posedge pclk) disable iff (!presetn) (&cnt[0]) && !selmsk_q[36] && evt[0]);

endmodule

`default_nettype wire

/* hw/pmes_regs.svh */
// Register offsets, field positions, reset values and masks of the monitor event-select block.
// Assumes a 32-bit APB slave in which each 64-bit control register is split into two aligned words.
`ifndef PMES_REGS_SVH
`define PMES_REGS_SVH

// ----------------------------------------------------------------------------
// Byte offsets
// ----------------------------------------------------------------------------
`define PMES_OFF_SELMSK_LO 8'h00
`define PMES_OFF_SELMSK_HI 8'h04
`define PMES_OFF_MATGAT_LO 8'h08
`define PMES_OFF_MATGAT_HI 8'h0c
`define PMES_OFF_COUNT0    8'h10
`define PMES_OFF_COUNT1    8'h14
`define PMES_OFF_COUNT2    8'h18
`define PMES_OFF_COUNT3    8'h1c

// ----------------------------------------------------------------------------
// Reset values and writable-bit masks (reserved bits are never stored)
// ----------------------------------------------------------------------------
`define PMES_RST_CTL      64'h0000_0000_0000_0000
`define PMES_SELMSK_WMASK 64'h3ff3_fff3_ffff_ffff
`define PMES_MATGAT_WMASK 64'h3ff3_ff3f_f3ff_0001

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define PMES_HI_MASK_LSB  52
`define PMES_LO_MASK_LSB  40
`define PMES_WRAP_LSB     36
`define PMES_MEMSEL_LSB   32
`define PMES_CHOICE_W     8
`define PMES_QUAL_W       10
`define PMES_PINS_OFF_BIT 0

// ----------------------------------------------------------------------------
// Event source codes
// ----------------------------------------------------------------------------
`define PMES_CARRY_CODE   8'hef
`define PMES_GEN_SRC_W    239

`endif

/* hw/pmes_pkg.sv */
// Types shared by the monitor event-select block.
// Assumes nothing beyond the header of constants.
`default_nettype none

package pmes_pkg;
  typedef logic [9:0]  pmes_qual_t;
  typedef logic [7:0]  pmes_choice_t;
  typedef logic [31:0] pmes_word_t;
endpackage

`default_nettype wire

/* hw/pmes_counter.sv */
// One event counter with saturate-or-wrap behaviour and a synchronous clear.
// Assumes increment and clear come from logic on the same clock.
`default_nettype none

module pmes_counter #(
  parameter int CNT_W = 32
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             clr,
  input  wire logic             inc,
  input  wire logic             wrap_en,
  output logic [CNT_W-1:0]      value_q,
  output logic                  carry_q
);

  logic [CNT_W-1:0] value_d;
  logic             carry_d;

  // ----------------------------------------------------------------------------
  // Next count
  // ----------------------------------------------------------------------------
  // Clear outranks counting so a control write always starts from zero.
  always_comb begin
    value_d = value_q;
    carry_d = 1'b0;
    if (clr) begin
      value_d = '0;
    end else if (inc) begin
      if (&value_q) begin
        if (wrap_en) begin
          value_d = '0;
          carry_d = 1'b1;
        end
      end else begin
        value_d = value_q + {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      value_q <= '0;
      carry_q <= 1'b0;
    end else begin
      value_q <= value_d;
      carry_q <= carry_d;
    end
  end

endmodule

`default_nettype wire

/* tb/test_perf_monitor_event_select.sv */
// Self-checking bench for the monitor event-select block, driven over APB and its event inputs.
// Assumes the hw/ files are compiled first; counters are shrunk to 4 bits so wrap is reachable.
`default_nettype none
`include "pmes_regs.svh"

module test_perf_monitor_event_select;
  timeunit 1ns;
  timeprecision 1ns;

  // ---------------------------------------------------------------------------
  // Signals and design instance
  // ---------------------------------------------------------------------------
  localparam int CW = 4;
  logic         pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]   paddr;
  logic [31:0]  pwdata, prdata, r;
  logic [238:0] event_src;
  logic [15:0]  cpu0_src;
  logic [9:0]   qual_tag;
  logic [15:0]  mset [4];
  logic [4:0]   mem_fixed;
  logic [3:0]   mon_out;
  logic [20:0]  mem_mon;
  logic         e;
  int           miscompares = 0;
  int           checks_done = 0;

  pmes_top #(.CNT_W(CW)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .event_src(event_src), .cpu0_fixed_src(cpu0_src), .qual_tag(qual_tag),
    .mem_signal_set_0(mset[0]), .mem_signal_set_1(mset[1]), .mem_signal_set_2(mset[2]),
    .mem_signal_set_3(mset[3]), .mem_fixed_src(mem_fixed), .mon_out(mon_out), .mem_mon(mem_mon));

  // A free-running 100 ns clock.
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  // ---------------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer; an idle cycle follows so no signal is driven twice in one step.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) miscompares++;
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(r, exp);
  endtask

  // Registered outputs need two edges after an input change to settle.
  task automatic settle();
    repeat (2) @(posedge pclk);
  endtask

  task automatic do_reset();
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
  endtask

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  // Writes all ones, expects reserved bits dropped, then a mid-run reset clears both control registers.
  task automatic t_fields();
    for (int i = 0; i < 4; i++) apb(1'b1, 8'(4 * i), 32'hffff_ffff);
    rd(`PMES_OFF_SELMSK_LO, 32'(`PMES_SELMSK_WMASK));
    rd(`PMES_OFF_SELMSK_HI, 32'(`PMES_SELMSK_WMASK >> 32));
    rd(`PMES_OFF_MATGAT_LO, 32'(`PMES_MATGAT_WMASK));
    rd(`PMES_OFF_MATGAT_HI, 32'(`PMES_MATGAT_WMASK >> 32));
    do_reset();
    for (int i = 0; i < 4; i++) rd(8'(4 * i), 32'h0);
  endtask

  // Each output picks its own source, including processor-0-only codes, and the gate forces zero.
  task automatic t_select();
    apb(1'b1, `PMES_OFF_SELMSK_LO, 32'hfff0_ee05);
    event_src <= {233'h0, 1'b1, 5'h0};
    cpu0_src <= 16'h0001;
    settle();
    chk({28'h0, mon_out}, 32'h5);
    event_src <= {1'b1, 238'h0};
    cpu0_src <= 16'h8000;
    settle();
    chk({28'h0, mon_out}, 32'ha);
    cpu0_src <= 16'h8001;
    apb(1'b1, `PMES_OFF_MATGAT_LO, 32'h1);
    settle();
    chk({28'h0, mon_out}, 32'h0);
    apb(1'b1, `PMES_OFF_MATGAT_LO, 32'h0);
    settle();
    chk({28'h0, mon_out}, 32'he);
  endtask

  // Low-pair mask qualifies outputs 0 and 1, high-pair mask outputs 2 and 3, each with its own match.
  task automatic t_qual();
    event_src[5] <= 1'b1;
    qual_tag <= 10'h155;
    apb(1'b1, `PMES_OFF_MATGAT_LO, 32'h0155_0000);
    apb(1'b1, `PMES_OFF_SELMSK_HI, 32'h0003_ff00);
    settle();
    chk({28'h0, mon_out}, 32'hd);
    apb(1'b1, `PMES_OFF_MATGAT_HI, 32'h0001_5500);
    apb(1'b1, `PMES_OFF_SELMSK_HI, 32'h3ff0_0000);
    settle();
    chk({28'h0, mon_out}, 32'h7);
  endtask

  // Every memory group choice routes its set to the low bits; the top bits never move.
  task automatic t_memgrp();
    for (int g = 0; g < 4; g++) begin
      apb(1'b1, `PMES_OFF_SELMSK_HI, 32'(g));
      settle();
      chk({11'h0, mem_mon}, {11'h0, mem_fixed, mset[g]});
      chk({27'h0, mem_mon[20:16]}, 32'h15);
    end
  endtask

  // Twenty events saturate a 4-bit counter, or wrap it to 4; each control write clears it.
  // Counter 1 counts the carry of counter 0, so it sees one event only when wrap is on.
  task automatic t_count();
    event_src <= '0;
    apb(1'b1, `PMES_OFF_MATGAT_LO, 32'h0);
    apb(1'b1, `PMES_OFF_SELMSK_HI, 32'h0);
    apb(1'b1, `PMES_OFF_SELMSK_LO, {16'h0, `PMES_CARRY_CODE, 8'h05});
    for (int w = 0; w < 2; w++) begin
      event_src[5] <= 1'b1;
      repeat (20) @(posedge pclk);
      event_src[5] <= 1'b0;
      settle();
      rd(`PMES_OFF_COUNT0, (w == 0) ? 32'((1 << CW) - 1) : 32'(20 % (1 << CW)));
      rd(`PMES_OFF_COUNT1, (w == 0) ? 32'h0 : 32'h1);
      apb(1'b1, `PMES_OFF_SELMSK_HI, 32'h10);
      rd(`PMES_OFF_COUNT0, 32'h0);
    end
  endtask

  task automatic t_unmapped();
    apb(1'b0, 8'h20, 32'h0);
    chk({31'h0, e}, 32'h1);
    chk(r, 32'h0);
  endtask

  // ---------------------------------------------------------------------------
  // Verdict, watchdog and main sequence
  // ---------------------------------------------------------------------------
  task automatic conclude();
    $display("checks %0d, mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // The whole run takes well under 1000 cycles, so 5000 means a hang.
  initial begin
    repeat (5000) @(posedge pclk);
    miscompares++;
    conclude();
  end

  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite} = 3'b000;
    paddr = 8'h00;
    pwdata = 32'h0;
    event_src = '0;
    cpu0_src = 16'h0;
    qual_tag = 10'h0;
    for (int i = 0; i < 4; i++) mset[i] = 16'ha5a0 + 16'(i);
    mem_fixed = 5'h15;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 4; i++) rd(8'(4 * i), 32'h0);
    t_fields();
    t_select();
    t_qual();
    t_memgrp();
    t_count();
    t_unmapped();
    conclude();
  end
endmodule

`default_nettype wire
